// File: core/hwm_regs.sv
// Hardware-monitor register bank: fan pulse clocks, sensor 1 temperature, status
`timescale 1ns/1ns
// ******************************************************************
// Overview of operation
// - Second pulse output clock code 000..100 gives 46.87 down to 2.93 kHz, reset 001; at 20 MHz with rounded-down steps the code gives 78.1 down to 3.0 kHz.
// - Bits 6:4 select first pulse output clock with the same code mapping.
// - Bit 3 of the pulse clock register enables the first pulse output.
// - Sensor-type bit 2: sensor 1 bipolar when 1, thermistor when 0.
// - Sensor-type bit 1: sensor 2 bipolar when 1, thermistor when 0.
// - Temperature high byte shows reading bits 8:1, read only.
// - Temperature low byte bit 7 shows reading bit 0, others read zero.
// - Config bits 4:3 set consecutive faults needed before the alarm asserts.
// - Config bit 1 picks comparator mode (0, reset) or interrupt mode (1).
// - Config bit 0 set stops monitoring of sensor 1.
// - Hysteresis low byte bit 7 holds hysteresis bit 0, others zero.
// - Limit high byte holds limit bits 8:1, reset 0x50 (80 C).
// - Limit low byte bit 7 writable limit bit 0, bits 6:0 read zero.
// - Beep control bit 5 forces the beep output active; reset inactive.
// - Status I flags fans, temperatures, +5V, +3.3V and core voltage out of limit.
// - Status II flags fan 3, -5V, -12V, +12V; bits 7:4 read zero.
// - Bank select bits 2:0 choose which bank answers at indexes 0x50-0x5F.
// ******************************************************************
module hwm_regs (
   // Clock, reset, enable
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire logic                      ce,
   // Register bus
   input  wire hwm_pkg::hwm_apb_req_t     apb_req,
   output      hwm_pkg::hwm_apb_rsp_t     apb_rsp,
   // Converter and limit comparators
   input  wire hwm_pkg::hwm_temp_sample_t temp_sample,
   input  wire hwm_pkg::hwm_limit_flags_t limit_flags,
   input  wire logic [7:0]                first_fan_duty,
   input  wire logic [7:0]                second_fan_duty,
   // Outputs to pins and neighbours
   output      logic                      first_fan_pulse_output,
   output      logic                      second_fan_pulse_output,
   output      logic                      overheat_alarm_pin_n,
   output      logic                      beep_force_active,
   output      logic                      sensor_one_type,
   output      logic                      sensor_two_type,
   output      logic                      sensor_halt,
   output      logic                      irq
);
   import hwm_pkg::*;

   hwm_state_t s_q;
   hwm_state_t s_d;

   // ******************************************************************
   // Decode helpers
   // ******************************************************************
   logic [7:0] idx;
   logic       addr_ok;
   logic       in_bank;
   logic       setup;
   logic       commit;
   logic [8:0] t_new;
   logic       hot;
   logic       cool;
   logic [2:0] fault_need;
   logic [IRQ_W-1:0] ev;
   logic [7:0] sts1_new;
   logic [7:0] sts2_new;
   logic [1:0][2:0] pwm_sel;
   logic [1:0][7:0] duty;

   assign idx     = apb_req.paddr[9:2];
   assign in_bank = (idx >= IDX_BANK_LO) && (idx <= IDX_BANK_HI);
   assign setup   = apb_req.psel && !apb_req.penable && !s_q.rsp.pready;
   assign commit  = apb_req.psel && apb_req.penable && s_q.rsp.pready;
   assign pwm_sel[0] = s_q.pwmclk[PWM1_SEL_LSB +: 3];
   assign pwm_sel[1] = s_q.pwmclk[PWM2_SEL_LSB +: 3];
   assign duty[0] = first_fan_duty;
   assign duty[1] = second_fan_duty;
   assign fault_need = {1'b0, s_q.cfg[CFG_FAULT_LSB +: 2]} + 3'h1;

   // Out-of-limit flags mapped into status layout
   assign sts1_new = {limit_flags.fan_two_flag, limit_flags.fan_one_flag,
                      limit_flags.temperature_one_flag, limit_flags.temperature_two_flag,
                      limit_flags.rail_5v_flag, limit_flags.rail_3v3_flag, 1'b0,
                      limit_flags.core_voltage_flag};
   assign sts2_new = {4'h0, limit_flags.fan_three_flag, limit_flags.neg_rail_5v_flag,
                      limit_flags.neg_rail_12v_flag, limit_flags.rail_12v_flag};

   // Reserved indexes answer zero; foreign ones error
   always_comb begin
      addr_ok = (apb_req.paddr[1:0] == 2'h0) && (apb_req.paddr[11:10] == 2'h0);
      if (in_bank) begin
         addr_ok = addr_ok && ((s_q.bank == BANK_MAIN) || (s_q.bank == BANK_ALARM));
      end else begin
         case (idx)
            IDX_TEMP, IDX_CFG, IDX_HYST, IDX_LIMIT, IDX_BANK,
            IDX_IRQ_STS, IDX_IRQ_MASK: addr_ok = addr_ok;
            default:                   addr_ok = 1'b0;
         endcase
      end
   end

   // Step length of one duty count for a clock code
   function automatic logic [7:0] step_len(input logic [2:0] sel);
      case (sel)
         3'h0:    step_len = 8'(PWM_CYC0);
         3'h1:    step_len = 8'(PWM_CYC1);
         3'h2:    step_len = 8'(PWM_CYC2);
         3'h3:    step_len = 8'(PWM_CYC3);
         3'h4:    step_len = 8'(PWM_CYC4);
         default: step_len = 8'(PWM_CYC4);
      endcase
   endfunction

   // Read mux; paired indexes pick the byte by their pointer
   function automatic logic [7:0] read_byte(input hwm_state_t st, input logic [7:0] i);
      logic [7:0] r;
      r = 8'h00;
      if ((i >= IDX_BANK_LO) && (i <= IDX_BANK_HI)) begin
         if (st.bank == BANK_MAIN) begin
            case (i)
               IDX_PWMCLK: r = st.pwmclk;
               IDX_SENSOR: r = st.sensor;
               default:    r = 8'h00;
            endcase
         end else if (st.bank == BANK_ALARM) begin
            case (i)
               IDX_BEEP: r = st.beep;
               IDX_STS1: r = st.sts1;
               IDX_STS2: r = st.sts2;
               default:  r = 8'h00;
            endcase
         end
      end else begin
         case (i)
            IDX_TEMP:     r = st.pair_low[0] ? {st.temp[0], 7'h00}  : st.temp[8:1];
            IDX_CFG:      r = st.cfg;
            IDX_HYST:     r = st.pair_low[2] ? {st.hyst[0], 7'h00}  : st.hyst[8:1];
            IDX_LIMIT:    r = st.pair_low[3] ? {st.limit[0], 7'h00} : st.limit[8:1];
            IDX_BANK:     r = {5'h00, st.bank};
            IDX_IRQ_STS:  r = {5'h00, st.irq_sts};
            IDX_IRQ_MASK: r = {5'h00, st.irq_mask};
            default:      r = 8'h00;
         endcase
      end
      return r;
   endfunction

   // ******************************************************************
   // Next state
   // ******************************************************************
   always_comb begin
      s_d   = s_q;
      ev    = '0;
      t_new = temp_sample.value;
      hot   = 1'b0;
      cool  = 1'b0;

      // Answer prepared in the setup cycle: no wait states
      s_d.rsp.pready = 1'b0;
      if (setup) begin
         s_d.rsp.pready  = 1'b1;
         s_d.rsp.pslverr = !addr_ok;
         s_d.rsp.prdata  = addr_ok && !apb_req.pwrite ? {24'h0, read_byte(s_q, idx)} : 32'h0;
         if (!apb_req.pwrite && addr_ok) begin
            case (idx)
               IDX_TEMP:  s_d.pair_low[0] = !s_q.pair_low[0];
               IDX_HYST:  s_d.pair_low[2] = !s_q.pair_low[2];
               IDX_LIMIT: s_d.pair_low[3] = !s_q.pair_low[3];
               default:   s_d.pair_low = s_q.pair_low;
            endcase
            // Interrupt mode: any register read releases the alarm
            if (s_q.cfg[CFG_MODE_BIT]) begin
               s_d.alarm_n = 1'b1;
            end
         end
      end

      if (commit && apb_req.pwrite && !s_q.rsp.pslverr) begin
         if (in_bank) begin
            if (s_q.bank == BANK_MAIN) begin
               case (idx)
                  IDX_PWMCLK: s_d.pwmclk = apb_req.pwdata[7:0];
                  IDX_SENSOR: s_d.sensor = apb_req.pwdata[7:0];
                  default:    s_d.pwmclk = s_q.pwmclk;
               endcase
            end else if (idx == IDX_BEEP) begin
               s_d.beep = apb_req.pwdata[7:0];
            end
         end else begin
            case (idx)
               IDX_CFG: s_d.cfg = apb_req.pwdata[7:0] & CFG_WMASK;
               IDX_HYST: begin
                  if (s_q.pair_low[2]) s_d.hyst[0] = apb_req.pwdata[7];
                  else                 s_d.hyst[8:1] = apb_req.pwdata[7:0];
                  s_d.pair_low[2] = !s_q.pair_low[2];
               end
               IDX_LIMIT: begin
                  if (s_q.pair_low[3]) s_d.limit[0] = apb_req.pwdata[7];
                  else                 s_d.limit[8:1] = apb_req.pwdata[7:0];
                  s_d.pair_low[3] = !s_q.pair_low[3];
               end
               IDX_BANK:     s_d.bank = apb_req.pwdata[2:0];
               IDX_IRQ_MASK: s_d.irq_mask = apb_req.pwdata[IRQ_W-1:0];
               IDX_IRQ_STS:  s_d.irq_sts = s_q.irq_sts & ~apb_req.pwdata[IRQ_W-1:0];
               default:      s_d.bank = s_q.bank;
            endcase
         end
      end

      // Real-time status follows the comparators
      s_d.sts1 = sts1_new;
      s_d.sts2 = sts2_new & STS2_MASK;
      ev[1] = |(sts1_new & ~s_q.sts1);
      ev[2] = |(sts2_new & ~s_q.sts2);

      // Temperature sampling and over-temperature alarm
      if (temp_sample.valid && !s_q.cfg[CFG_HALT_BIT]) begin
         s_d.temp = t_new;
         hot  = $signed(t_new) >= $signed(s_q.limit);
         cool = $signed(t_new) <  $signed(s_q.hyst);
         if (hot) begin
            if (s_q.fault_cnt < fault_need) begin
               s_d.fault_cnt = s_q.fault_cnt + 3'h1;
            end
         end else begin
            s_d.fault_cnt = 3'h0;
         end
         if (hot && (s_q.fault_cnt + 3'h1 >= fault_need) && s_q.armed) begin
            s_d.alarm_n = 1'b0;
            s_d.armed   = 1'b0;
            ev[0]       = s_q.alarm_n;
         end
         if (cool) begin
            s_d.armed = 1'b1;
            // Comparator mode releases only on falling below hysteresis
            if (!s_q.cfg[CFG_MODE_BIT]) begin
               s_d.alarm_n = 1'b1;
            end
         end
      end

      // Sticky events: a new event wins over a same-cycle clear
      s_d.irq_sts = s_d.irq_sts | ev;
      s_d.irq     = |(s_d.irq_sts & s_d.irq_mask);

      // Fan pulse generators, one per output
      for (int k = 0; k < 2; k++) begin
         if (s_q.pwm_pre[k] + 8'h1 >= step_len(pwm_sel[k])) begin
            s_d.pwm_pre[k]  = 8'h00;
            s_d.pwm_step[k] = s_q.pwm_step[k] + 8'h1;
         end else begin
            s_d.pwm_pre[k] = s_q.pwm_pre[k] + 8'h1;
         end
         s_d.pwm_out[k] = (s_q.pwm_step[k] < duty[k]) || (duty[k] == 8'hFF);
      end
      // First output idles low unless enabled
      if (!s_q.pwmclk[PWM1_EN_BIT]) begin
         s_d.pwm_out[0] = 1'b0;
      end
   end

   // ******************************************************************
   // State register
   // ******************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q          <= '0;
         s_q.pwmclk   <= RST_PWMCLK;
         s_q.sensor   <= RST_SENSOR;
         s_q.cfg      <= RST_CFG;
         s_q.limit    <= RST_LIMIT;
         s_q.hyst     <= RST_HYST;
         s_q.temp     <= RST_TEMP;
         s_q.alarm_n  <= 1'b1;
         s_q.armed    <= 1'b1;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   // ******************************************************************
   // Outputs, all straight from state
   // ******************************************************************
   assign apb_rsp                 = s_q.rsp;
   assign first_fan_pulse_output  = s_q.pwm_out[0];
   assign second_fan_pulse_output = s_q.pwm_out[1];
   assign overheat_alarm_pin_n    = s_q.alarm_n;
   assign beep_force_active       = s_q.beep[BEEP_FORCE_BIT];
   assign sensor_one_type         = s_q.sensor[SENSOR1_BIT];
   assign sensor_two_type         = s_q.sensor[SENSOR2_BIT];
   assign sensor_halt             = s_q.cfg[CFG_HALT_BIT];
   assign irq                     = s_q.irq;

endmodule

// File: include/hwm_pkg.sv
// Constants, register map and carrier types of the hardware-monitor register bank
package hwm_pkg;

   // ******************************************************************
   // Clock and fan pulse timing
   // ******************************************************************
   localparam int unsigned CLK_HZ        = 20_000_000;
   localparam int unsigned PWM_STEPS     = 256;
   // Pulse frequencies in units of 10 mHz, as printed in kHz
   localparam int unsigned PWM_FREQ0_CHZ = 4_687_000;
   localparam int unsigned PWM_FREQ1_CHZ = 2_343_000;
   localparam int unsigned PWM_FREQ2_CHZ = 1_172_000;
   localparam int unsigned PWM_FREQ3_CHZ = 585_000;
   localparam int unsigned PWM_FREQ4_CHZ = 293_000;

   // Cycles per duty step, rounded down, never below one
   function automatic int unsigned hwm_step_cycles(input int unsigned f_chz);
      longint unsigned c;
      c = (longint'(CLK_HZ) * 100) / (longint'(f_chz) * PWM_STEPS);
      return (c < 1) ? 1 : int'(c);
   endfunction

   localparam int unsigned PWM_CYC0 = hwm_step_cycles(PWM_FREQ0_CHZ);
   localparam int unsigned PWM_CYC1 = hwm_step_cycles(PWM_FREQ1_CHZ);
   localparam int unsigned PWM_CYC2 = hwm_step_cycles(PWM_FREQ2_CHZ);
   localparam int unsigned PWM_CYC3 = hwm_step_cycles(PWM_FREQ3_CHZ);
   localparam int unsigned PWM_CYC4 = hwm_step_cycles(PWM_FREQ4_CHZ);

   // ******************************************************************
   // Register indexes (byte address is four times the index)
   // ******************************************************************
   localparam logic [7:0] IDX_TEMP     = 8'h00;
   localparam logic [7:0] IDX_CFG      = 8'h01;
   localparam logic [7:0] IDX_HYST     = 8'h02;
   localparam logic [7:0] IDX_LIMIT    = 8'h03;
   localparam logic [7:0] IDX_BANK     = 8'h4E;
   localparam logic [7:0] IDX_BANK_LO  = 8'h50;
   localparam logic [7:0] IDX_BANK_HI  = 8'h5F;
   localparam logic [7:0] IDX_BEEP     = 8'h53;
   localparam logic [7:0] IDX_STS1     = 8'h59;
   localparam logic [7:0] IDX_STS2     = 8'h5A;
   localparam logic [7:0] IDX_PWMCLK   = 8'h5B;
   localparam logic [7:0] IDX_SENSOR   = 8'h5D;
   localparam logic [7:0] IDX_IRQ_STS  = 8'h60;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h61;
   localparam logic [2:0] BANK_MAIN    = 3'h0;
   localparam logic [2:0] BANK_ALARM   = 3'h4;

   // ******************************************************************
   // Field positions and reset values
   // ******************************************************************
   localparam int PWM2_SEL_LSB  = 0;
   localparam int PWM1_EN_BIT   = 3;
   localparam int PWM1_SEL_LSB  = 4;
   localparam int SENSOR2_BIT   = 1;
   localparam int SENSOR1_BIT   = 2;
   localparam int CFG_HALT_BIT  = 0;
   localparam int CFG_MODE_BIT  = 1;
   localparam int CFG_FAULT_LSB = 3;
   localparam int BEEP_FORCE_BIT = 5;
   localparam logic [7:0] CFG_WMASK   = 8'h1B;
   localparam logic [7:0] STS2_MASK   = 8'h0F;
   localparam logic [7:0] RST_PWMCLK  = 8'h11;
   localparam logic [7:0] RST_SENSOR  = 8'h00;
   localparam logic [7:0] RST_CFG     = 8'h00;
   localparam logic [8:0] RST_LIMIT   = 9'h0A0;
   localparam logic [8:0] RST_HYST    = 9'h000;
   localparam logic [8:0] RST_TEMP    = 9'h000;
   localparam int IRQ_W = 3;

   // ******************************************************************
   // Carriers
   // ******************************************************************
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } hwm_apb_req_t;

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } hwm_apb_rsp_t;

   typedef struct packed {
      logic       valid;
      logic [8:0] value;
   } hwm_temp_sample_t;

   typedef struct packed {
      logic fan_three_flag;
      logic neg_rail_5v_flag;
      logic neg_rail_12v_flag;
      logic rail_12v_flag;
      logic fan_two_flag;
      logic fan_one_flag;
      logic temperature_one_flag;
      logic temperature_two_flag;
      logic rail_5v_flag;
      logic rail_3v3_flag;
      logic core_voltage_flag;
   } hwm_limit_flags_t;

   typedef struct packed {
      hwm_apb_rsp_t     rsp;
      logic [2:0]       bank;
      logic [3:0]       pair_low;
      logic [8:0]       temp;
      logic [7:0]       cfg;
      logic [8:0]       hyst;
      logic [8:0]       limit;
      logic [7:0]       beep;
      logic [7:0]       pwmclk;
      logic [7:0]       sensor;
      logic [7:0]       sts1;
      logic [7:0]       sts2;
      logic [IRQ_W-1:0] irq_sts;
      logic [IRQ_W-1:0] irq_mask;
      logic             irq;
      logic             alarm_n;
      logic [2:0]       fault_cnt;
      logic             armed;
      logic [1:0][7:0]  pwm_pre;
      logic [1:0][7:0]  pwm_step;
      logic [1:0]       pwm_out;
   } hwm_state_t;

endpackage

// File: test/hwm_regs_checker.sv
// Concurrent assertions for the hardware-monitor register bank
`timescale 1ns/1ns
module hwm_regs_checker (
   // Clock, reset, enable
   input wire logic                      pclk,
   input wire logic                      presetn,
   input wire logic                      ce,
   // Register bus
   input wire hwm_pkg::hwm_apb_req_t     apb_req,
   input wire hwm_pkg::hwm_apb_rsp_t     apb_rsp,
   // Sources
   input wire hwm_pkg::hwm_temp_sample_t temp_sample,
   input wire hwm_pkg::hwm_limit_flags_t limit_flags,
   // Outputs
   input wire logic                      first_fan_pulse_output,
   input wire logic                      second_fan_pulse_output,
   input wire logic                      overheat_alarm_pin_n,
   input wire logic                      beep_force_active,
   input wire logic                      sensor_one_type,
   input wire logic                      sensor_two_type,
   input wire logic                      sensor_halt,
   input wire logic                      irq
);
   import hwm_pkg::*;
   logic [2:0] bank_q;
   logic       setup;
   logic       wr_done;
   hwm_limit_flags_t f;
   assign f       = limit_flags;
   assign setup   = apb_req.psel && !apb_req.penable && ce && !apb_rsp.pready;
   assign wr_done = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready && ce;
   // Bank select shadow for banked read checks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bank_q <= 3'h0;
      end else if (wr_done && !apb_rsp.pslverr && apb_req.paddr == 12'h138) begin
         bank_q <= apb_req.pwdata[2:0];
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_rd(logic [7:0] idx);
      setup && !apb_req.pwrite && apb_req.paddr == {2'b00, idx, 2'b00};
   endsequence
   chk_zero_wait: assert property (setup |=> apb_rsp.pready)
      else $error("pready missing after setup");
   chk_ready_pulse: assert property (apb_rsp.pready && ce |=> !apb_rsp.pready)
      else $error("pready held too long");
   chk_misalign_err: assert property (setup && apb_req.paddr[1:0] != 2'b00
      |=> apb_rsp.pready && apb_rsp.pslverr) else $error("misaligned access not refused");
   chk_bank_refused: assert property (s_rd(8'h53) ##0 (bank_q != 3'h0 && bank_q != 3'h4)
      |=> apb_rsp.pslverr) else $error("bad bank not refused");
   chk_status_one: assert property (s_rd(8'h59) ##0 (bank_q == 3'h4 && $stable(f))
      |=> apb_rsp.prdata == {24'h0, f[6:1], 1'b0, f[0]}) else $error("status one layout wrong");
   chk_status_two: assert property (s_rd(8'h5A) ##0 (bank_q == 3'h4 && $stable(f))
      |=> apb_rsp.prdata == {28'h0, f[10:7]}) else $error("status two layout wrong");
   chk_freeze_ce: assert property (!ce |=> $stable(apb_rsp) && $stable(irq)
      && $stable(overheat_alarm_pin_n) && $stable({first_fan_pulse_output,
      second_fan_pulse_output})) else $error("state moved while disabled");
   chk_alarm_cause: assert property ($fell(overheat_alarm_pin_n)
      |-> $past(temp_sample.valid)) else $error("alarm fell without a sample");
   chk_halt_write: assert property ($changed(sensor_halt) |-> $past(wr_done))
      else $error("halt moved without a write");
   chk_types_write: assert property ($changed({sensor_one_type, sensor_two_type})
      |-> $past(wr_done)) else $error("sensor type moved alone");
   chk_beep_write: assert property ($changed(beep_force_active) |-> $past(wr_done))
      else $error("beep moved without a write");
endmodule

bind hwm_regs hwm_regs_checker u_hwm_regs_checker (
   .pclk(pclk), .presetn(presetn), .ce(ce), .apb_req(apb_req), .apb_rsp(apb_rsp),
   .temp_sample(temp_sample), .limit_flags(limit_flags),
   .first_fan_pulse_output(first_fan_pulse_output),
   .second_fan_pulse_output(second_fan_pulse_output),
   .overheat_alarm_pin_n(overheat_alarm_pin_n), .beep_force_active(beep_force_active),
   .sensor_one_type(sensor_one_type), .sensor_two_type(sensor_two_type),
   .sensor_halt(sensor_halt), .irq(irq));

// File: test/hwm_regs_tb.sv
// Self-checking testbench for the hardware-monitor register bank
`timescale 1ns/1ns
module hwm_regs_tb;
   import hwm_pkg::*;
   localparam longint FREQ_CHZ [5] = '{4_687_000, 2_343_000, 1_172_000, 585_000, 293_000};
   logic             pclk;
   logic             presetn;
   logic             ce;
   hwm_apb_req_t     apb_req;
   hwm_apb_rsp_t     apb_rsp;
   hwm_temp_sample_t temp_sample;
   hwm_limit_flags_t limit_flags;
   logic [7:0]       first_fan_duty;
   logic [7:0]       second_fan_duty;
   logic             fan1_out, fan2_out, alarm_n, beep_on, type1, type2, halt, irq;
   logic [31:0]      rd_v;
   logic             err_v;
   int               bad_count = 0;
   int               comparisons = 0;
   int               cycles = 0;

   hwm_regs u_hwm_regs (
      .pclk(pclk), .presetn(presetn), .ce(ce), .apb_req(apb_req), .apb_rsp(apb_rsp),
      .temp_sample(temp_sample), .limit_flags(limit_flags),
      .first_fan_duty(first_fan_duty), .second_fan_duty(second_fan_duty),
      .first_fan_pulse_output(fan1_out), .second_fan_pulse_output(fan2_out),
      .overheat_alarm_pin_n(alarm_n), .beep_force_active(beep_on),
      .sensor_one_type(type1), .sensor_two_type(type2), .sensor_halt(halt), .irq(irq));

   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   // ******************************************************************
   // Bus and check tasks
   // ******************************************************************
   task automatic stop_test;
      if (bad_count == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 90000) begin
         bad_count++;
         stop_test();
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   function automatic logic [11:0] ad(input logic [7:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction
   function automatic int steps(input int c);
      return int'((longint'(CLK_HZ) * 100) / (FREQ_CHZ[c] * 256));
   endfunction
   // Read data is taken at the edge where pready is high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      int k = 0;
      @(posedge pclk);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (apb_rsp.pready !== 1'b1 && k < 20);
      rd_v = apb_rsp.prdata;
      err_v = apb_rsp.pslverr;
      apb_req <= '0;
      if (k == 20) chk("pready", 32'h0, 32'h1);
      // Outputs launched by the write are settled one edge later
      @(posedge pclk);
   endtask
   task automatic rc(input logic [7:0] idx, input logic [31:0] exp, input string nm);
      apb(1'b0, ad(idx), 32'h0);
      chk(nm, rd_v, exp);
   endtask
   // Paired index: high byte, then bit 0 in bit 7
   task automatic rp(input logic [7:0] idx, input logic [8:0] v, input string nm);
      rc(idx, {24'h0, v[8:1]}, nm);
      rc(idx, {24'h0, v[0], 7'h00}, nm);
   endtask
   task automatic wp(input logic [7:0] idx, input logic [8:0] v);
      apb(1'b1, ad(idx), {24'h0, v[8:1]});
      apb(1'b1, ad(idx), {24'h0, v[0], 7'h7F});
   endtask
   task automatic sample(input logic [8:0] v);
      @(posedge pclk);
      temp_sample <= '{valid: 1'b1, value: v};
      @(posedge pclk);
      temp_sample.valid <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask
   task automatic period(input bit sel, output int n);
      int k, r;
      logic p, c;
      r = 0;
      n = 0;
      p = 1'b1;
      for (k = 0; k < 16000 && r < 2; k++) begin
         @(posedge pclk);
         c = sel ? fan2_out : fan1_out;
         if (r == 1) n++;
         if (c === 1'b1 && p === 1'b0) r++;
         p = c;
      end
   endtask

   // ******************************************************************
   // Main sequence
   // ******************************************************************
   initial begin
      logic [8:0] v;
      logic [7:0] s;
      logic       acc;
      int         n, i;
      presetn = 1'b0;
      ce = 1'b1;
      apb_req = '0;
      temp_sample = '0;
      limit_flags = '0;
      first_fan_duty = 8'h80;
      second_fan_duty = 8'h80;
      void'($urandom(32'hc0a8));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rc(IDX_PWMCLK, 32'h11, "pwmclk");
      rc(IDX_CFG, 32'h0, "cfg");
      rp(IDX_LIMIT, 9'h0A0, "limit");
      apb(1'b1, ad(IDX_PWMCLK), 32'h0);
      acc = 1'b0;
      repeat (300) begin
         @(posedge pclk);
         acc = acc | fan1_out;
      end
      chk("pwm1_off", acc, 32'h0);
      for (i = 0; i < 5; i++) begin
         apb(1'b1, ad(IDX_PWMCLK), {25'h0, i[2:0], 1'b1, i[2:0]});
         period(1'b1, n);
         chk("pwm2_period", n, 256 * steps(i));
         period(1'b0, n);
         chk("pwm1_period", n, 256 * steps(i));
      end
      s = 8'($urandom) & 8'h06;
      apb(1'b1, ad(IDX_SENSOR), {24'h0, s});
      chk("type1", type1, s[2]);
      chk("type2", type2, s[1]);
      apb(1'b1, ad(IDX_SENSOR) | 12'h001, 32'hFF);
      chk("misaligned", err_v, 1'b1);
      rc(IDX_SENSOR, {24'h0, s}, "sensor");
      v = 9'(1 + $urandom % 159);
      sample(v);
      rp(IDX_TEMP, v, "temp");
      apb(1'b1, ad(IDX_CFG), 32'h1);
      sample(~v);
      rp(IDX_TEMP, v, "temp_halted");
      apb(1'b1, ad(IDX_CFG), 32'hFF);
      rc(IDX_CFG, 32'h1B, "cfg_rw");
      chk("halt", halt, 1'b1);
      v = 9'($urandom);
      wp(IDX_HYST, v);
      rp(IDX_HYST, v, "hyst");
      wp(IDX_LIMIT, 9'h050);
      wp(IDX_HYST, 9'h020);
      apb(1'b1, ad(IDX_IRQ_STS), 32'h7);
      apb(1'b1, ad(IDX_IRQ_MASK), 32'h1);
      apb(1'b1, ad(IDX_CFG), 32'h8);
      sample(9'h060);
      chk("alarm_one", alarm_n, 1'b1);
      sample(9'h060);
      chk("alarm_two", alarm_n, 1'b0);
      chk("irq_set", irq, 1'b1);
      apb(1'b1, ad(IDX_IRQ_MASK), 32'h0);
      chk("irq_mask", irq, 1'b0);
      apb(1'b1, ad(IDX_IRQ_MASK), 32'h1);
      chk("irq_unmask", irq, 1'b1);
      apb(1'b1, ad(IDX_IRQ_STS), 32'h1);
      chk("irq_clear", irq, 1'b0);
      sample(9'h010);
      chk("alarm_cmp", alarm_n, 1'b1);
      apb(1'b1, ad(IDX_CFG), 32'hA);
      sample(9'h060);
      sample(9'h060);
      sample(9'h010);
      chk("alarm_int", alarm_n, 1'b0);
      rc(IDX_CFG, 32'hA, "cfg_int");
      chk("alarm_read", alarm_n, 1'b1);
      ce <= 1'b0;
      repeat (4) @(posedge pclk);
      ce <= 1'b1;
      apb(1'b1, ad(IDX_BANK), 32'h4);
      for (i = 1; i >= 0; i--) begin
         apb(1'b1, ad(IDX_BEEP), {26'h0, i[0], 5'h00});
         chk("beep", beep_on, i[0]);
         rc(IDX_BEEP, {26'h0, i[0], 5'h00}, "beep_reg");
      end
      rc(IDX_PWMCLK, 32'h0, "bank4_gap");
      for (i = 0; i < 3; i++) begin
         limit_flags <= hwm_limit_flags_t'($urandom);
         repeat (3) @(posedge pclk);
         rc(IDX_STS1, {24'h0, limit_flags[6:1], 1'b0, limit_flags[0]}, "sts1");
         rc(IDX_STS2, {28'h0, limit_flags[10:7]}, "sts2");
      end
      apb(1'b1, ad(IDX_BANK), 32'h1);
      apb(1'b0, ad(IDX_BEEP), 32'h0);
      chk("bank1_err", err_v, 1'b1);
      apb(1'b1, ad(IDX_BANK), 32'h0);
      rc(IDX_BEEP, 32'h0, "bank0_gap");
      chk("bank0_err", err_v, 1'b0);
      apb(1'b0, ad(8'h20), 32'h0);
      chk("unmapped", err_v, 1'b1);
      stop_test();
   end
endmodule
